// file: logic/adcseq_cfg.svh
// Constants for the conversion mode sequencer: timing and reset values.
// Assumes a 40 MHz system clock; included by the package file, whose macros the design uses.
`ifndef ADCSEQ_CFG_SVH
`define ADCSEQ_CFG_SVH
`define ADCSEQ_CLK_HZ       40000000
`define ADCSEQ_OSC_HZ       1000000
`define ADCSEQ_MOD_DIV      4
`define ADCSEQ_RESULT_W     16
`define ADCSEQ_RATE_W       3
`define ADCSEQ_RATE_RST     3'h4
`define ADCSEQ_RESULT_RST   16'h0000
`define ADCSEQ_OSR_8        16'h7A12
`define ADCSEQ_OSR_16       16'h3D09
`define ADCSEQ_OSR_32       16'h1E84
`define ADCSEQ_OSR_64       16'h0F42
`define ADCSEQ_OSR_128      16'h07A1
`define ADCSEQ_OSR_250      16'h03E8
`define ADCSEQ_OSR_475      16'h020E
`define ADCSEQ_OSR_860      16'h0122
`endif

// file: logic/adcseq_pkg.sv
// Types shared by the conversion mode sequencer.
// Assumes nothing beyond the constants header.
`include "adcseq_cfg.svh"
package adcseq_pkg;
  typedef enum logic [2:0] {
    ADCSEQ_POWER_DOWN = 3'b001,
    ADCSEQ_CONVERT    = 3'b010,
    ADCSEQ_STORE      = 3'b100
  } adcseq_state_e;
endpackage

// file: logic/adcseq_top.sv
// Conversion mode sequencer with decimating filter and result register.
// Assumes the modulator bit is valid on each modulator strobe it receives.
// What this block does
// - Results are 16-bit codes proportional to input
// - Filter turns modulator bitstream into codes
// - Decimate to selected rate; OSR = fmod/DR
// - Lower rate averages more modulator samples
// - Single-shot: one conversion per request only
// - Single-shot result written into result register
// - After single-shot store, power down
// - Continuous: next conversion starts without gap
// - Continuous results arrive at programmed rate
// - Result readable anytime, last completed only
// - Modulator clock is oscillator divided by four
// - Eight data rates chosen by 3-bit field
// - Conversion lasts one over data rate
`timescale 1ns/1ps
module adcseq_top
  import adcseq_pkg::*;
#(
  parameter int OSC_DIV = `ADCSEQ_CLK_HZ / `ADCSEQ_OSC_HZ
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        mod_bit,
  input  wire logic        continuous,
  input  wire logic        start_req,
  input  wire logic [2:0]  rate_sel,
  output logic             mod_clk_en,
  output logic             busy,
  output logic             result_valid,
  output logic [15:0]      result
);

  localparam int OSC_W = $clog2(OSC_DIV + 1);
  localparam int MOD_W = 2;

  // Modulator samples per conversion for each rate setting
  function automatic logic [15:0] osr_of(input logic [2:0] sel);
    case (sel)
      3'h0: begin
        osr_of = `ADCSEQ_OSR_8;
      end
      3'h1: begin
        osr_of = `ADCSEQ_OSR_16;
      end
      3'h2: begin
        osr_of = `ADCSEQ_OSR_32;
      end
      3'h3: begin
        osr_of = `ADCSEQ_OSR_64;
      end
      3'h4: begin
        osr_of = `ADCSEQ_OSR_128;
      end
      3'h5: begin
        osr_of = `ADCSEQ_OSR_250;
      end
      3'h6: begin
        osr_of = `ADCSEQ_OSR_475;
      end
      default: begin
        osr_of = `ADCSEQ_OSR_860;
      end
    endcase
  endfunction

  adcseq_state_e    state;
  adcseq_state_e    next_state;
  logic [OSC_W-1:0] osc_cnt;
  logic [MOD_W-1:0] mod_cnt;
  logic             osc_tick;
  logic             mod_tick;
  logic [2:0]       rate_lat;
  logic [2:0]       next_rate;
  logic [15:0]      osr;
  logic [15:0]      sample_cnt;
  logic [15:0]      ones_cnt;
  logic             win_last;
  logic             take_start;
  logic             pend;
  logic             full_scale;
  logic [31:0]      scaled;
  logic [15:0]      code;

  // Free running divide, so strobes keep their spacing across modes
  assign osc_tick = (osc_cnt == OSC_W'(OSC_DIV - 1));

  assign mod_tick = osc_tick && (mod_cnt == MOD_W'(`ADCSEQ_MOD_DIV - 1));

  assign mod_clk_en = mod_tick && (state == ADCSEQ_CONVERT);

  assign busy = (state != ADCSEQ_POWER_DOWN);

  assign osr = osr_of(rate_lat);

  assign win_last = mod_tick && (sample_cnt == osr - 16'h1);

  assign take_start = continuous || pend || start_req;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt <= '0;
    end else if (osc_tick) begin
      osc_cnt <= '0;
    end else begin
      osc_cnt <= osc_cnt + OSC_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mod_cnt <= '0;
    end else if (osc_tick) begin
      mod_cnt <= mod_cnt + MOD_W'(1);
    end
  end

  // Request seen during a conversion starts exactly one more
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend <= 1'b0;
    end else if (state == ADCSEQ_POWER_DOWN) begin
      pend <= 1'b0;
    end else if (start_req) begin
      pend <= 1'b1;
    end
  end

  always_comb begin
    next_state = state;
    next_rate  = rate_lat;
    case (state)
      ADCSEQ_POWER_DOWN: begin
        if (take_start) begin
          next_state = ADCSEQ_CONVERT;
          next_rate  = rate_sel;
        end
      end
      ADCSEQ_CONVERT: begin
        if (win_last) begin
          next_state = ADCSEQ_STORE;
        end
      end
      ADCSEQ_STORE: begin
        if (continuous) begin
          next_state = ADCSEQ_CONVERT;
          next_rate  = rate_sel;
        end else begin
          next_state = ADCSEQ_POWER_DOWN;
        end
      end
      default: begin
        next_state = ADCSEQ_POWER_DOWN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ADCSEQ_POWER_DOWN;
    end else begin
      state <= next_state;
    end
  end

  // Rate held for a whole window; a change applies next conversion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_lat <= `ADCSEQ_RATE_RST;
    end else begin
      rate_lat <= next_rate;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_cnt <= 16'h0000;
    end else if (state != ADCSEQ_CONVERT) begin
      sample_cnt <= 16'h0000;
    end else if (mod_tick) begin
      sample_cnt <= sample_cnt + 16'h0001;
    end
  end

  // Counting ones averages the bitstream over the whole window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ones_cnt <= 16'h0000;
    end else if (state != ADCSEQ_CONVERT) begin
      ones_cnt <= 16'h0000;
    end else if (mod_tick) begin
      ones_cnt <= ones_cnt + {15'h0000, mod_bit};
    end
  end

  assign scaled = ({16'h0000, ones_cnt} << 16) / {16'h0000, osr};

  // All ones would wrap to the most negative code, so clamp it
  assign full_scale = (ones_cnt == osr);

  assign code = full_scale ? 16'h7FFF : (scaled[15:0] ^ 16'h8000);

  // Whole-word update keeps reads free of partial codes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result <= `ADCSEQ_RESULT_RST;
    end else if (state == ADCSEQ_STORE) begin
      result <= code;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_valid <= 1'b0;
    end else if (state == ADCSEQ_STORE) begin
      result_valid <= 1'b1;
    end
  end

endmodule

// file: sim/adcseq_mod_src.sv
// Modulator bitstream source for the sequencer bench.
// Assumes a new bit is taken at each modulator strobe.
`timescale 1ns/1ps
module adcseq_mod_src (
  input  wire logic       clk,
  input  wire logic       mod_clk_en,
  input  wire logic [1:0] pat,
  output logic            mod_bit
);
  logic ph = 1'b0;
  // Toggle only on a strobe, so the density is exact
  always @(posedge clk) if (mod_clk_en) ph <= ~ph;
  assign mod_bit = pat[1] ? ph : pat[0];
endmodule

// file: sim/adcseq_chk_sva.sv
// Port checks of the conversion sequencer.
// Assumes binding into adcseq_top.
`timescale 1ns/1ps
module adcseq_chk #(
  parameter int OSC_DIV = 40
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        continuous,
  input wire logic        start_req,
  input wire logic        mod_clk_en,
  input wire logic        busy,
  input wire logic        result_valid,
  input wire logic [15:0] result
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_strobe_idle: assert property (mod_clk_en |-> busy)
    else $error("strobe while idle");
  a_strobe_gap: assert property (mod_clk_en |=> !mod_clk_en [*7])
    else $error("strobes too close");
  a_start_taken: assert property (!busy && start_req |=> busy)
    else $error("request ignored");
  a_stay_down: assert property (!busy && !start_req && !continuous |=> !busy)
    else $error("start without request");
  a_cont_run: assert property (busy && continuous |=> busy)
    else $error("gap in continuous mode");
  a_cont_start: assert property (!busy && continuous |=> busy)
    else $error("continuous not started");
  a_result_hold: assert property ($changed(result) |-> $past(busy))
    else $error("result moved while idle");
  a_valid_stay: assert property (result_valid |=> result_valid)
    else $error("valid flag dropped");
  cover property ($fell(busy));
  cover property (continuous && $changed(result));
  cover property ($rose(result_valid));
endmodule
bind adcseq_top adcseq_chk #(.OSC_DIV(OSC_DIV)) chk (.clk(clk), .rst_n(rst_n),
  .continuous(continuous), .start_req(start_req), .mod_clk_en(mod_clk_en),
  .busy(busy), .result_valid(result_valid), .result(result));

// file: sim/tb.sv
// Bench for the sequencer: single-shot and continuous runs.
// Assumes OSC_DIV of 2, so a strobe every 8 clocks.
`timescale 1ns/1ps
module tb;
  logic clk = 0, rst_n = 0, continuous = 0, start_req = 0, mod_bit;
  logic mod_clk_en, busy, result_valid;
  logic [2:0] rate_sel = 3'h7;
  logic [1:0] pat = 2'h0;
  logic [15:0] result;
  int error_cnt = 0, checks = 0, cyc = 0, n;
  always #12.5 clk = ~clk;
  adcseq_top #(.OSC_DIV(2)) uut (.clk(clk), .rst_n(rst_n), .mod_bit(mod_bit),
    .continuous(continuous), .start_req(start_req), .rate_sel(rate_sel),
    .mod_clk_en(mod_clk_en), .busy(busy), .result_valid(result_valid),
    .result(result));
  adcseq_mod_src src (.clk(clk), .mod_clk_en(mod_clk_en), .pat(pat),
    .mod_bit(mod_bit));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t %h %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task conv(input logic [2:0] r, input logic [1:0] p, input logic [15:0] e,
            input int osr);
    n = 0;
    @(posedge clk);
    rate_sel <= r;
    pat <= p;
    start_req <= 1'b1;
    @(posedge clk);
    start_req <= 1'b0;
    #1;
    while (busy) begin
      n += mod_clk_en;
      @(posedge clk);
      #1;
    end
    chk(n, osr);
    @(posedge clk);
    #1;
    chk(result, e);
    chk(result_valid, 1);
    n = 0;
    repeat (40) begin
      @(posedge clk);
      #1;
      n += busy;
    end
    chk(n, 0);
    $display("single-shot test done");
  endtask
  task cont;
    @(posedge clk);
    pat <= 2'h0;
    continuous <= 1'b1;
    n = 0;
    repeat (5000) begin
      @(posedge clk);
      #1;
      n += !busy;
    end
    chk(n, 0);
    chk(result, 16'h8000);
    @(posedge clk);
    continuous <= 1'b0;
    while (busy) @(posedge clk);
    $display("continuous test done");
  endtask
  always @(posedge clk) begin
    cyc++;
    // Whole run needs about 16000 cycles
    if (cyc == 30000) begin
      error_cnt++;
      end_of_test;
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    conv(3'h7, 2'h0, 16'h8000, 290);
    conv(3'h6, 2'h2, 16'h0000, 526);
    conv(3'h7, 2'h1, 16'h7FFF, 290);
    cont;
    end_of_test;
  end
endmodule
